// ==== verilog/fcp_pkg.sv ====
// Constants, types and SFR map of the flash command and protection controller.
// Assumes a 25 MHz system clock and an 8-bit SFR write/read port from the core.
package fcp_pkg;
	localparam logic [7:0] SFR_CMD = 8'hB9;
	localparam logic [7:0] SFR_ACC_KEY = 8'hBA;
	localparam logic [7:0] SFR_PROT_KEY = 8'hBB;
	localparam logic [7:0] SFR_DATA = 8'hBC;
	localparam logic [7:0] SFR_WP_LOW = 8'hBD;
	localparam logic [7:0] SFR_WP_HIGH = 8'hBE;
	localparam logic [7:0] SFR_RP = 8'hBF;
	localparam logic [7:0] SFR_ADR_LOW = 8'hC6;
	localparam logic [7:0] SFR_ADR_HIGH = 8'hC7;
	localparam logic [7:0] CMD_WRITE = 8'h01;
	localparam logic [7:0] CMD_ERASE_PAGE = 8'h02;
	localparam logic [7:0] CMD_ERASE_ALL = 8'h03;
	localparam logic [7:0] CMD_READ = 8'h04;
	localparam logic [7:0] CMD_ERASE_WRITE = 8'h05;
	localparam logic [7:0] CMD_PROTECT = 8'h08;
	localparam logic [7:0] ACCESS_KEY = 8'h3B;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] RST_PROT = 8'hFF;
	localparam logic [7:0] RST_ADR = 8'h00;
	localparam logic [7:0] UNAVAILABLE = 8'hFF;
	localparam int ADDR_W = 14;
	localparam int DEPTH = 16384;
	localparam logic [13:0] PROT_BASE = 14'h3FFA;
	localparam logic [13:0] LAST_ADDR = 14'h3FFF;
	localparam logic [8:0] PAGE_LAST_OFS = 9'h1FF;
	localparam logic [4:0] LAST_PAGE = 5'h1F;
	localparam logic [3:0] BOOT_DONE = 4'h8;
	localparam logic [2:0] PROT_BYTES = 3'h6;
	// Slots of the six protection bytes, counted up from the base address.
	localparam int SLOT_KEY = 0;
	localparam int SLOT_RP = 1;
	localparam int SLOT_WP0 = 2;
	localparam int SLOT_WP1 = 3;
	localparam int SLOT_WP2 = 4;
	localparam int SLOT_WP3 = 5;
	localparam int CLK_NS = 40;
	localparam int T_WRITE_NS = 30000;
	localparam int T_READ_NS = 100;
	localparam int T_ERASE_PAGE_MS = 20;
	localparam int T_ERASE_ALL_MS = 200;
	localparam int T_ERASE_WRITE_MS = 21;
	localparam int WRITE_CYC = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERASE_PAGE_CYC = T_ERASE_PAGE_MS * (1000000 / CLK_NS);
	localparam int ERASE_ALL_CYC = T_ERASE_ALL_MS * (1000000 / CLK_NS);
	localparam int ERASE_WRITE_CYC = T_ERASE_WRITE_MS * (1000000 / CLK_NS);

	typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_ERASE, ST_PROG, ST_PROT, ST_WAIT} fcp_state_t;

	typedef struct packed {
		fcp_state_t state;
		logic [3:0] cnt;
		logic [22:0] timer;
		logic [13:0] ptr;
		logic all;
		logic then_prog;
		logic [13:0] maddr;
		logic we;
		logic er;
		logic [7:0] wdata;
		logic [7:0] flash_data;
		logic [7:0] adrh;
		logic [7:0] adrl;
		logic [7:0] wp0;
		logic [7:0] wp1;
		logic [7:0] rp;
		logic [7:0] pkey;
		logic keyok;
		logic [7:0] cmd;
		logic [5:0][7:0] act;
		logic dl_mode;
		logic [2:0] sync;
		logic stall;
		logic [7:0] rdata;
		logic [7:0] code;
	} fcp_regs_t;
endpackage

// ==== verilog/fcp_array.sv ====
// Flash array of the controller: 16 kB, one sequencer port and one code port.
// Assumes the sequencer never programs and erases in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module fcp_array
	import fcp_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic [13:0] i_addr,
	input wire logic i_wr_en,
	input wire logic i_erase,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	input wire logic [13:0] i_code_addr,
	output logic [7:0] o_code_data
);
	logic [7:0] mem [DEPTH];

	// The array starts erased, as a fresh part would.
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = ERASED_BYTE;
		end
	end

	// Programming only clears bits; erasing sets the byte back to all ones.
	always_ff @(posedge i_sys_clk) begin
		if (i_erase) begin
			mem[i_addr] <= ERASED_BYTE;
		end else if (i_wr_en) begin
			mem[i_addr] <= mem[i_addr] & i_wdata;
		end
		o_rdata <= mem[i_addr];
		o_code_data <= mem[i_code_addr];
	end
endmodule
`default_nettype wire

// ==== verilog/fcp_ctrl.sv ====
// Flash command sequencer with page protection, loaded from flash at reset.
// Assumes the core writes SFRs one per cycle and holds off while stalled.
`timescale 1ns/1ps
`default_nettype none
module fcp_ctrl
	import fcp_pkg::*;
#(
	parameter int ERASE_PAGE_CYCLES = ERASE_PAGE_CYC,
	parameter int ERASE_ALL_CYCLES = ERASE_ALL_CYC,
	parameter int ERASE_WRITE_CYCLES = ERASE_WRITE_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_rd,
	output logic [7:0] o_sfr_rdata,
	output logic o_core_stall,
	input wire logic [13:0] i_code_table_read_addr,
	output logic [7:0] o_code_table_read_data,
	input wire logic i_download_enable_pin_n,
	output logic o_download_mode,
	output logic o_wdt_lock_en,
	output logic o_prot_active
);
	fcp_regs_t q;
	fcp_regs_t d;
	logic [7:0] mem_rdata;
	logic [7:0] code_rdata;
	logic [31:0] wp_bits;
	logic [7:0] rp_bits;
	logic prot_on;
	logic wr_blocked;
	logic rd_blocked;
	logic key_match;
	logic cmd_wr;
	logic cmd_go;
	logic [22:0] held_cnt_q;

	fcp_array u_array (
		.i_sys_clk(i_sys_clk),
		.i_addr(q.maddr),
		.i_wr_en(q.we),
		.i_erase(q.er),
		.i_wdata(q.wdata),
		.o_rdata(mem_rdata),
		.i_code_addr(i_code_table_read_addr),
		.o_code_data(code_rdata)
	);

	// Protection as loaded at reset; pages and groups are decoded from the address.
	assign wp_bits = {q.act[SLOT_WP3], q.act[SLOT_WP2], q.act[SLOT_WP1], q.act[SLOT_WP0]};
	assign rp_bits = q.act[SLOT_RP];
	assign prot_on = ~wp_bits[LAST_PAGE];
	assign wr_blocked = prot_on & ~wp_bits[{q.adrh[5:1]}];
	assign rd_blocked = prot_on & ~rp_bits[q.adrh[5:3]] & ({q.adrh[5:0], q.adrl} < PROT_BASE);
	assign key_match = (q.act[SLOT_KEY] == RST_PROT) | (q.pkey == q.act[SLOT_KEY]);
	assign cmd_wr = i_sfr_wr & (i_sfr_addr == SFR_CMD) & (q.state == ST_IDLE);
	assign cmd_go = cmd_wr & q.keyok;

	// Next state of every register of the block.
	always_comb begin
		d = q;
		d.we = 1'b0;
		d.er = 1'b0;
		d.sync = {q.sync[1:0], i_download_enable_pin_n};
		if (q.timer != '0) begin
			d.timer = q.timer - 23'h000001;
		end
		case (q.state)
			// Load the six protection bytes, two cycles behind each address.
			ST_BOOT: begin
				d.maddr = PROT_BASE + {10'h000, q.cnt};
				if (q.cnt >= 4'h2 && q.cnt < BOOT_DONE) begin
					d.act[q.cnt[2:0] - 3'h2] = mem_rdata;
				end
				if (q.cnt < BOOT_DONE) begin
					d.cnt = q.cnt + 4'h1;
				end else if (q.sync[1] == q.sync[2]) begin
					d.dl_mode = ~q.sync[2];
					d.state = ST_IDLE;
				end
			end
			// Take SFR writes and launch commands.
			ST_IDLE: begin
				if (i_sfr_wr) begin
					d.keyok = 1'b0;
					case (i_sfr_addr)
						SFR_ACC_KEY: d.keyok = (i_sfr_wdata == ACCESS_KEY);
						SFR_PROT_KEY: d.pkey = i_sfr_wdata;
						SFR_DATA: d.flash_data = i_sfr_wdata;
						SFR_WP_LOW: d.wp0 = i_sfr_wdata;
						SFR_WP_HIGH: d.wp1 = i_sfr_wdata;
						SFR_RP: d.rp = i_sfr_wdata;
						SFR_ADR_LOW: d.adrl = i_sfr_wdata;
						SFR_ADR_HIGH: d.adrh = i_sfr_wdata;
						default: d.keyok = 1'b0;
					endcase
				end
				if (cmd_go) begin
					d.cmd = i_sfr_wdata;
					d.maddr = {q.adrh[5:0], q.adrl};
					d.ptr = {q.adrh[5:1], 9'h000};
					d.all = 1'b0;
					d.then_prog = 1'b0;
					d.cnt = 4'h0;
					case (i_sfr_wdata)
						CMD_WRITE: begin
							if (!wr_blocked) begin
								d.state = ST_PROG;
								d.timer = 23'(WRITE_CYC);
							end
						end
						CMD_ERASE_PAGE: begin
							if (!wr_blocked) begin
								d.state = ST_ERASE;
								d.timer = 23'(ERASE_PAGE_CYCLES);
							end
						end
						CMD_ERASE_ALL: begin
							d.state = ST_ERASE;
							d.ptr = '0;
							d.all = 1'b1;
							d.timer = 23'(ERASE_ALL_CYCLES);
						end
						CMD_READ: begin
							d.state = ST_WAIT;
							d.timer = 23'(READ_CYC);
						end
						CMD_ERASE_WRITE: begin
							if (!wr_blocked) begin
								d.state = ST_ERASE;
								d.then_prog = 1'b1;
								d.timer = 23'(ERASE_WRITE_CYCLES);
							end
						end
						CMD_PROTECT: begin
							if (key_match) begin
								d.state = ST_PROT;
								d.timer = 23'(WRITE_CYC);
							end
						end
						default: d.state = ST_IDLE;
					endcase
				end
			end
			// Erase one byte a cycle over the page or the whole array.
			ST_ERASE: begin
				d.maddr = q.ptr;
				d.er = 1'b1;
				d.ptr = q.ptr + 14'h0001;
				if ((q.all && q.ptr == LAST_ADDR) || (!q.all && q.ptr[8:0] == PAGE_LAST_OFS)) begin
					d.state = q.then_prog ? ST_PROG : ST_WAIT;
				end
			end
			// Program the data byte at the command address; bits only clear.
			ST_PROG: begin
				d.maddr = {q.adrh[5:0], q.adrl};
				d.wdata = q.flash_data;
				d.we = 1'b1;
				d.state = ST_WAIT;
			end
			// Program the six protection bytes; the AND keeps bits from returning to 1.
			ST_PROT: begin
				d.maddr = PROT_BASE + {11'h000, q.cnt[2:0]};
				d.we = 1'b1;
				case (q.cnt[2:0])
					3'h0: d.wdata = (q.act[SLOT_KEY] == RST_PROT) ? q.pkey : ERASED_BYTE;
					3'h1: d.wdata = q.rp;
					3'h2: d.wdata = q.wp0;
					3'h3: d.wdata = q.wp1;
					3'h4: d.wdata = q.adrl;
					default: d.wdata = q.adrh;
				endcase
				d.cnt = q.cnt + 4'h1;
				if (q.cnt[2:0] == PROT_BYTES - 3'h1) begin
					d.state = ST_WAIT;
				end
			end
			// Hold the core until the operation time has run out.
			ST_WAIT: begin
				if (q.cmd == CMD_READ && q.timer == 23'h000001) begin
					d.flash_data = rd_blocked ? UNAVAILABLE : mem_rdata;
				end
				if (q.timer <= 23'h000001) begin
					d.state = ST_IDLE;
					d.keyok = 1'b0;
				end
			end
			default: d.state = ST_IDLE;
		endcase
		d.stall = (d.state != ST_IDLE);
		d.code = code_rdata;
		if (i_sfr_rd) begin
			case (i_sfr_addr)
				SFR_CMD: d.rdata = q.cmd;
				SFR_ACC_KEY: d.rdata = {7'h00, q.keyok};
				SFR_PROT_KEY: d.rdata = q.pkey;
				SFR_DATA: d.rdata = q.flash_data;
				SFR_WP_LOW: d.rdata = q.wp0;
				SFR_WP_HIGH: d.rdata = q.wp1;
				SFR_RP: d.rdata = q.rp;
				SFR_ADR_LOW: d.rdata = q.adrl;
				SFR_ADR_HIGH: d.rdata = q.adrh;
				default: d.rdata = 8'h00;
			endcase
		end
	end

	// Register the whole state; protection reads as unprotected until loaded.
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
			q.state <= ST_BOOT;
			q.stall <= 1'b1;
			q.wp0 <= RST_PROT;
			q.wp1 <= RST_PROT;
			q.rp <= RST_PROT;
			q.pkey <= RST_PROT;
			q.adrh <= RST_ADR;
			q.adrl <= RST_ADR;
			q.act <= {6{RST_PROT}};
			q.sync <= 3'h7;
		end else begin
			q <= d;
		end
	end

	assign o_sfr_rdata = q.rdata;
	assign o_core_stall = q.stall;
	assign o_code_table_read_data = q.code;
	assign o_download_mode = q.dl_mode;
	assign o_wdt_lock_en = q.act[SLOT_KEY][7];
	assign o_prot_active = ~q.act[SLOT_WP3][7];

	// A keyed command write that launches an operation stalls the core from the next cycle.
	property p_stall_on_cmd;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(cmd_go && d.state != ST_IDLE) |=> o_core_stall;
	endproperty
	a_stall_on_cmd: assert property (p_stall_on_cmd) else $error("core not stalled after command");

	// Without the access key a command leaves the sequencer idle and writes nothing.
	property p_no_key;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(cmd_wr && !q.keyok) |=> (q.state == ST_IDLE) ##1 (!q.we && !q.er);
	endproperty
	a_no_key: assert property (p_no_key) else $error("unkeyed command was executed");

	// Counts the cycles the core has been held since the last launched command.
	// The duration checks read it, since the operation times are far too long for a fixed delay.
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			held_cnt_q <= 23'h000000;
		end else if (cmd_go) begin
			held_cnt_q <= 23'h000000;
		end else if (o_core_stall) begin
			held_cnt_q <= held_cnt_q + 23'h000001;
		end
	end

	// A byte write or a protection command holds the core for the full write time.
	property p_write_time;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		($fell(o_core_stall) && (q.cmd == CMD_WRITE || q.cmd == CMD_PROTECT)) |-> (held_cnt_q == 23'(WRITE_CYC));
	endproperty
	a_write_time: assert property (p_write_time) else $error("byte write duration wrong");

	// Page and array erases hold the core for their own erase times.
	property p_erase_time;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		($fell(o_core_stall) && (q.cmd == CMD_ERASE_PAGE || q.cmd == CMD_ERASE_ALL)) |->
			(held_cnt_q == ((q.cmd == CMD_ERASE_ALL) ? 23'(ERASE_ALL_CYCLES) : 23'(ERASE_PAGE_CYCLES)));
	endproperty
	a_erase_time: assert property (p_erase_time) else $error("erase duration wrong");

	// Erase-then-write and byte read hold the core for their own times.
	property p_mixed_time;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		($fell(o_core_stall) && (q.cmd == CMD_READ || q.cmd == CMD_ERASE_WRITE)) |->
			(held_cnt_q == ((q.cmd == CMD_READ) ? 23'(READ_CYC) : 23'(ERASE_WRITE_CYCLES)));
	endproperty
	a_mixed_time: assert property (p_mixed_time) else $error("read or erase-write duration wrong");

	// A write byte command programs exactly once, two cycles after launch.
	property p_write_prog;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(cmd_go && i_sfr_wdata == CMD_WRITE && !wr_blocked) |-> ##2 (q.we && q.wdata == $past(q.flash_data)) ##1 !q.we;
	endproperty
	a_write_prog: assert property (p_write_prog) else $error("byte not programmed");

	// A byte read completes within a handful of cycles.
	property p_read_time;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(cmd_go && i_sfr_wdata == CMD_READ) |-> ##[3:5] (q.state == ST_IDLE);
	endproperty
	a_read_time: assert property (p_read_time) else $error("byte read too slow");

	// Active protection changes only while loading at reset.
	property p_prot_stable;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(q.state != ST_BOOT) |=> $stable(q.act);
	endproperty
	a_prot_stable: assert property (p_prot_stable) else $error("protection changed before reset");

	// A protected page refuses byte writes and page erases.
	property p_wp_block;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(cmd_go && wr_blocked && (i_sfr_wdata == CMD_WRITE || i_sfr_wdata == CMD_ERASE_PAGE)) |=> (q.state == ST_IDLE);
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("protected page modified");

	// A wrong protection key refuses the protection command.
	property p_key_block;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(cmd_go && i_sfr_wdata == CMD_PROTECT && !key_match) |=> (q.state == ST_IDLE) ##1 !q.we;
	endproperty
	a_key_block: assert property (p_key_block) else $error("protection changed without key");

	// Download mode holds once the boot load is over.
	property p_dl_stable;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(q.state != ST_BOOT) |=> $stable(o_download_mode);
	endproperty
	a_dl_stable: assert property (p_dl_stable) else $error("download mode changed");

	// A page erase never touches a byte outside the page of the command address.
	property p_erase_span;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(q.er && !q.all) |-> (q.maddr[13:9] == q.adrh[5:1]);
	endproperty
	a_erase_span: assert property (p_erase_span) else $error("erase left its page");

	// The last erased byte of an erase-then-write is followed by programming the data byte.
	property p_erase_prog;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(q.state == ST_ERASE && q.then_prog && q.ptr[8:0] == PAGE_LAST_OFS) |->
			##2 (q.we && q.wdata == q.flash_data && q.maddr == {q.adrh[5:0], q.adrl});
	endproperty
	a_erase_prog: assert property (p_erase_prog) else $error("byte not programmed after erase");

	// The protection command programs only the six protection bytes.
	property p_prot_span;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(q.we && q.cmd == CMD_PROTECT) |-> (q.maddr >= PROT_BASE);
	endproperty
	a_prot_span: assert property (p_prot_span) else $error("protection write outside its bytes");

	// A stored protection key is written with all ones, so it never changes.
	property p_key_fixed;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		(q.we && q.cmd == CMD_PROTECT && q.maddr == PROT_BASE && q.act[SLOT_KEY] != RST_PROT) |->
			(q.wdata == ERASED_BYTE);
	endproperty
	a_key_fixed: assert property (p_key_fixed) else $error("stored protection key modified");
endmodule
`default_nettype wire

// ==== test/fcp_core_model.sv ====
// Core-side partner: issues SFR writes and reads as the processor would.
// Assumes each call starts just after a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module fcp_core_model
	import fcp_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_stall,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	output logic o_rd
);
	// The bus idles with no strobe at time zero.
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_wdata = 8'h00;
		o_rd = 1'b0;
	end

	// One write; the core holds off while the controller stalls it.
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (i_stall !== 1'b0 && n < 20000) begin
			@(negedge i_sys_clk);
			n++;
		end
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_sys_clk);
		o_wr = 1'b0;
		o_wdata = ~d; // Released data must not keep showing the last value.
		// One idle cycle, so the next call never raises the strobe in this time step.
		@(negedge i_sys_clk);
	endtask

	// One read; the answer is taken a full cycle after the strobe.
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_sys_clk);
		o_rd = 1'b0;
		@(negedge i_sys_clk);
		d = i_rdata;
	endtask

	// The fixed access key goes directly before every command write.
	task automatic flash_cmd(input logic [7:0] code);
		sfr_write(SFR_ACC_KEY, ACCESS_KEY);
		sfr_write(SFR_CMD, code);
	endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the flash command and protection controller.
// Assumes the core partner model and shortened erase counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fcp_pkg::*;
	logic clk, rst_n, pin_n, wr, rd, stall, dl, wdt, pact;
	logic [7:0] adr, wd, rdat, got, ct_d;
	logic [13:0] ct_a;
	int mem[int];
	int num_errors = 0;
	int num_checks = 0;
	int seed = 32474;
	int act_wp;
	int act_rp;
	bit act_on;

	// Design under test with short erase counts.
	fcp_ctrl #(.ERASE_PAGE_CYCLES(600), .ERASE_ALL_CYCLES(17000), .ERASE_WRITE_CYCLES(700)) u_fcp_ctrl (
		.i_sys_clk(clk), .i_reset_n(rst_n), .i_sfr_addr(adr), .i_sfr_wr(wr), .i_sfr_wdata(wd),
		.i_sfr_rd(rd), .o_sfr_rdata(rdat), .o_core_stall(stall), .i_code_table_read_addr(ct_a),
		.o_code_table_read_data(ct_d), .i_download_enable_pin_n(pin_n), .o_download_mode(dl),
		.o_wdt_lock_en(wdt), .o_prot_active(pact));

	// Processor side of the SFR port.
	fcp_core_model u_fcp_core_model (.i_sys_clk(clk), .i_stall(stall), .i_rdata(rdat), .o_addr(adr),
		.o_wr(wr), .o_wdata(wd), .o_rd(rd));

	// Free-running 25 MHz clock.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic int mrd(int a);
		return mem.exists(a) ? mem[a] : 255;
	endfunction

	// Value the read command should return under the latched protection.
	function automatic int exp_rd(int a);
		if (act_on && !act_rp[a >> 11] && a < 'h3FFA)
			return 255;
		return mrd(a);
	endfunction

	function automatic bit wr_ok(int a);
		return !(act_on && !act_wp[a >> 9]);
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic w(input logic [7:0] a, input logic [7:0] d);
		u_fcp_core_model.sfr_write(a, d);
	endtask

	task automatic note(input string s);
		$display("test %s done", s);
	endtask

	// Waits, with a bound, until the core is released.
	task automatic wait_idle();
		int n;
		n = 0;
		while (stall !== 1'b0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		if (n == 20000) begin
			num_errors++;
			$display("BAD at %0t: stall never cleared", $time);
		end
	endtask

	// Reset for four cycles, then latch the expected protection from the model.
	task automatic do_reset(input logic pin);
		pin_n = pin;
		rst_n = 1'b0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		act_wp = {8'(mrd('h3FFF)), 8'(mrd('h3FFE)), 8'(mrd('h3FFD)), 8'(mrd('h3FFC))};
		act_rp = mrd('h3FFB);
		act_on = !act_wp[31];
		wait_idle();
		check(8'(pact), 8'(act_on));
		check(8'(wdt), 8'(mrd('h3FFA) >> 7));
		check(8'(dl), 8'(!pin));
	endtask

	task automatic ct(input int a);
		ct_a = 14'(a);
		repeat (3) @(negedge clk);
		check(ct_d, 8'(mrd(a)));
	endtask

	// One flash command with its data and address set up first.
	task automatic op(input logic [7:0] c, input int a, input int d, input bit key);
		bit ok;
		w(SFR_DATA, 8'(d));
		w(SFR_ADR_HIGH, 8'(a >> 8));
		w(SFR_ADR_LOW, 8'(a));
		if (key)
			u_fcp_core_model.flash_cmd(c);
		else
			w(SFR_CMD, c);
		ok = key && c inside {CMD_WRITE, CMD_ERASE_PAGE, CMD_ERASE_ALL, CMD_READ, CMD_ERASE_WRITE};
		ok = ok && (c inside {CMD_READ, CMD_ERASE_ALL} || wr_ok(a));
		@(negedge clk);
		check(8'(stall), 8'(ok));
		wait_idle();
		u_fcp_core_model.sfr_read(SFR_ACC_KEY, got);
		check(got, 8'h00);
		if (ok && c inside {CMD_ERASE_PAGE, CMD_ERASE_WRITE})
			for (int i = a & 'h3E00; i < (a & 'h3E00) + 512; i++)
				mem.delete(i);
		if (ok && c == CMD_ERASE_ALL)
			mem.delete();
		if (ok && c inside {CMD_WRITE, CMD_ERASE_WRITE})
			mem[a] = mrd(a) & d;
		if (ok && c == CMD_READ) begin
			u_fcp_core_model.sfr_read(SFR_DATA, got);
			check(got, 8'(exp_rd(a)));
		end
	endtask

	// Protection programming; the key entry must match the stored key unless none is stored.
	task automatic protect(input int wp, input int rp, input int k);
		bit ok;
		w(SFR_WP_LOW, 8'(wp));
		w(SFR_WP_HIGH, 8'(wp >> 8));
		w(SFR_ADR_LOW, 8'(wp >> 16));
		w(SFR_ADR_HIGH, 8'(wp >> 24));
		w(SFR_RP, 8'(rp));
		w(SFR_PROT_KEY, 8'(k));
		u_fcp_core_model.flash_cmd(CMD_PROTECT);
		ok = mrd('h3FFA) == 255 || mrd('h3FFA) == k;
		@(negedge clk);
		check(8'(stall), 8'(ok));
		wait_idle();
		if (ok) begin
			mem['h3FFA] = mrd('h3FFA) & k;
			for (int i = 0; i < 4; i++)
				mem['h3FFC + i] = mrd('h3FFC + i) & ((wp >> (8 * i)) & 255);
			mem['h3FFB] = mrd('h3FFB) & rp;
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog against a hang, at about twice the expected run length.
	initial begin
		#1600000;
		num_errors++;
		$display("BAD at %0t: run did not finish", $time);
		print_verdict();
	end

	// Main sequence.
	initial begin
		int a1;
		int a2;
		int d1;
		rst_n = 1'b0;
		pin_n = 1'b1;
		ct_a = 14'h0000;
		do_reset(1'b1);
		note("reset");
		a1 = 'h3C00 + ($random(seed) & 'h1FF);
		d1 = $random(seed) & 'h7F;
		op(CMD_WRITE, a1, d1, 1'b1);
		op(CMD_READ, a1, 0, 1'b1);
		ct(a1);
		note("write and read");
		a2 = 'h0400 + ($random(seed) & 'h1FE);
		op(CMD_WRITE, a2 + 1, d1, 1'b1);
		op(CMD_ERASE_WRITE, a2, d1 ^ 'h55, 1'b1);
		op(CMD_READ, a2 + 1, 0, 1'b1);
		op(CMD_READ, a2, 0, 1'b1);
		op(CMD_ERASE_PAGE, a2 + 1, 0, 1'b1);
		op(CMD_READ, a2, 0, 1'b1);
		note("erase");
		op(CMD_WRITE, a2, d1, 1'b0);
		op(8'h06, a2, d1, 1'b1);
		op(CMD_READ, a2, 0, 1'b1);
		note("refused");
		protect('h7FFF_FFFE, 'h7F, 'h23);
		op(CMD_WRITE, 'h0010, d1, 1'b1);
		do_reset(1'b0);
		op(CMD_WRITE, 'h0020, d1, 1'b1);
		op(CMD_WRITE, 'h0220, d1, 1'b1);
		op(CMD_READ, a1, 0, 1'b1);
		ct(a1);
		op(CMD_READ, 'h3FFB, 0, 1'b1);
		protect('hFFFF_FFFF, 'hFF, 'hFF);
		protect('hFFFF_FFFD, 'hFF, 'h23);
		op(CMD_ERASE_PAGE, 'h0020, 0, 1'b1);
		note("protection");
		op(CMD_ERASE_ALL, 0, 0, 1'b1);
		do_reset(1'b1);
		op(CMD_READ, a1, 0, 1'b1);
		note("erase all");
		print_verdict();
	end
endmodule
`default_nettype wire
